// file: core/cmt_timer.sv
// Compare match timer: one 16-bit or two 8-bit up-counters with compare,
// toggle outputs, flags and interrupt requests, on a byte-wide CPU bus.
// Assumes bus strobes are one-cycle pulses synchronous to clk_in.
`timescale 1ns/1ns
module cmt_timer
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // CPU byte bus
   input wire logic [3:0] addr_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [7:0] wdata_in,
   output logic [7:0] rdata_out,
   // Interrupt enables and request clears from the interrupt controller
   input wire logic high_irq_enable_in,
   input wire logic low_irq_enable_in,
   input wire logic high_irq_clear_in,
   input wire logic low_irq_clear_in,
   // Power state and count sources
   input wire logic module_run_in,
   input wire logic low_power_in,
   input wire logic sub_tick_in,
   input wire logic event_input_pin_in,
   // Pins and requests
   output logic high_toggle_pin_out,
   output logic low_toggle_pin_out,
   output logic high_irq_request_flag_out,
   output logic low_irq_request_flag_out,
   output logic high_irq_out,
   output logic low_irq_out
);
   import cmt_pkg::*;

   typedef struct packed
   {
      logic [7:0] ctrl;
      logic [7:0] stat;
      logic [7:0] cnt_h;
      logic [7:0] cnt_l;
      logic [7:0] cmp_h;
      logic [7:0] cmp_l;
      logic [7:0] temp;
      logic [7:0] rdata;
      logic pin_h;
      logic pin_l;
      logic req_h;
      logic req_l;
      logic irq_h;
      logic irq_l;
   } cmt_state_t;

   cmt_state_t s_r;
   cmt_state_t s_nxt;
   logic tick_h;
   logic tick_l;
   logic mode8;
   logic wr_ctrl;
   logic wr_stat;
   logic wr_cnt_h;
   logic wr_cnt_l;
   logic wr_cmp_h;
   logic wr_cmp_l;
   logic match_h;
   logic match_l;
   logic ovf_h;
   logic ovf_l;

   // Count source selection and prescaling
   cmt_clk_sel i_cmt_clk_sel
   (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .run_in(module_run_in),
      .low_power_in(low_power_in),
      .sub_tick_in(sub_tick_in),
      .event_in(event_input_pin_in),
      .sel_h_in(s_r.ctrl[CTRL_CKSH_HI:CTRL_CKSH_LO]),
      .sel_l_in(s_r.ctrl[CTRL_CKSL_EXT:CTRL_CKSL_LO]),
      .tick_h_out(tick_h),
      .tick_l_out(tick_l)
   );

   // Write decode
   assign mode8 = s_r.ctrl[CTRL_MODE];
   assign wr_ctrl = wr_in && (addr_in == ADDR_CTRL);
   assign wr_stat = wr_in && (addr_in == ADDR_STAT);
   assign wr_cnt_h = wr_in && (addr_in == ADDR_CNT_H);
   assign wr_cnt_l = wr_in && (addr_in == ADDR_CNT_L);
   assign wr_cmp_h = wr_in && (addr_in == ADDR_CMP_H);
   assign wr_cmp_l = wr_in && (addr_in == ADDR_CMP_L);

   // Match and overflow events; the matcher runs on the count tick only
   always_comb
   begin
      match_h = 1'b0;
      match_l = 1'b0;
      ovf_h = 1'b0;
      ovf_l = 1'b0;
      if (!mode8)
      begin
         // Cascaded: the low select clocks the whole 16 bits
         match_h = tick_l && ({s_r.cnt_h, s_r.cnt_l} == {s_r.cmp_h, s_r.cmp_l});
         if (wr_cmp_l && ({s_r.temp, wdata_in} != {s_r.cnt_h, s_r.cnt_l}))
         begin
            match_h = 1'b0;
         end
         ovf_h = tick_l && ({s_r.cnt_h, s_r.cnt_l} == {BYTE_MAX, BYTE_MAX}) &&
                 !(match_h && s_r.stat[STAT_HIGH_CLEAR_ON_MATCH]) && !wr_cnt_l;
         ovf_l = tick_l && (s_r.cnt_l == BYTE_MAX) && !wr_cnt_l;
      end
      else
      begin
         match_h = tick_h && (s_r.cnt_h == s_r.cmp_h);
         match_l = tick_l && (s_r.cnt_l == s_r.cmp_l);
         if (wr_cmp_l && (wdata_in != s_r.cnt_l))
         begin
            match_l = 1'b0;
         end
         ovf_h = tick_h && (s_r.cnt_h == BYTE_MAX) &&
                 !(match_h && s_r.stat[STAT_HIGH_CLEAR_ON_MATCH]) && !wr_cnt_h;
         ovf_l = tick_l && (s_r.cnt_l == BYTE_MAX) &&
                 !(match_l && s_r.stat[STAT_LOW_CLEAR_ON_MATCH]) && !wr_cnt_l;
      end
   end

   // Next state: counters, registers, flags, pins and read data
   always_comb
   begin
      s_nxt = s_r;
      // Counting; a CPU write below takes priority over the count
      if (!mode8)
      begin
         if (match_h && s_r.stat[STAT_HIGH_CLEAR_ON_MATCH])
         begin
            {s_nxt.cnt_h, s_nxt.cnt_l} = {CNT_RESET, CNT_RESET};
         end
         else if (tick_l)
         begin
            {s_nxt.cnt_h, s_nxt.cnt_l} = {s_r.cnt_h, s_r.cnt_l} + 16'h0001;
         end
      end
      else
      begin
         if (match_h && s_r.stat[STAT_HIGH_CLEAR_ON_MATCH])
         begin
            s_nxt.cnt_h = CNT_RESET;
         end
         else if (tick_h)
         begin
            s_nxt.cnt_h = s_r.cnt_h + 8'h01;
         end
         if (match_l && s_r.stat[STAT_LOW_CLEAR_ON_MATCH])
         begin
            s_nxt.cnt_l = CNT_RESET;
         end
         else if (tick_l)
         begin
            s_nxt.cnt_l = s_r.cnt_l + 8'h01;
         end
      end
      // Byte writes; in 16-bit mode the upper byte waits in the temporary
      if (wr_ctrl)
      begin
         s_nxt.ctrl = wdata_in;
      end
      if (wr_cnt_h || wr_cmp_h)
      begin
         if (!mode8)
         begin
            s_nxt.temp = wdata_in;
         end
         else if (wr_cnt_h)
         begin
            s_nxt.cnt_h = wdata_in;
         end
         else
         begin
            s_nxt.cmp_h = wdata_in;
         end
      end
      if (wr_cnt_l)
      begin
         s_nxt.cnt_l = wdata_in;
         if (!mode8)
         begin
            s_nxt.cnt_h = s_r.temp;
         end
      end
      if (wr_cmp_l)
      begin
         s_nxt.cmp_l = wdata_in;
         if (!mode8)
         begin
            s_nxt.cmp_h = s_r.temp;
         end
      end
      // Status: enables are written; flags only clear on a 0, and a set wins
      if (wr_stat)
      begin
         s_nxt.stat = (wdata_in & 8'h33) | (wdata_in & s_r.stat & 8'hcc);
      end
      s_nxt.stat[STAT_HIGH_OVERFLOW_FLAG] = s_nxt.stat[STAT_HIGH_OVERFLOW_FLAG] | ovf_h;
      s_nxt.stat[STAT_LOW_OVERFLOW_FLAG] = s_nxt.stat[STAT_LOW_OVERFLOW_FLAG] | ovf_l;
      s_nxt.stat[STAT_HIGH_MATCH_FLAG] = s_nxt.stat[STAT_HIGH_MATCH_FLAG] | match_h;
      s_nxt.stat[STAT_LOW_MATCH_FLAG] = s_nxt.stat[STAT_LOW_MATCH_FLAG] | match_l;
      // Request flags: set beats a clear from the interrupt controller
      s_nxt.req_h = (s_r.req_h && !high_irq_clear_in) || match_h ||
                    (ovf_h && s_r.stat[STAT_HIGH_OVERFLOW_IRQ_ENABLE]);
      s_nxt.req_l = (s_r.req_l && !low_irq_clear_in) || (mode8 && match_l) ||
                    (ovf_l && s_r.stat[STAT_LOW_OVERFLOW_IRQ_ENABLE]);
      s_nxt.irq_h = s_nxt.req_h && high_irq_enable_in;
      s_nxt.irq_l = s_nxt.req_l && low_irq_enable_in;
      // Pins: a control write sets the level outright, else a match toggles
      if (wr_ctrl)
      begin
         s_nxt.pin_h = wdata_in[CTRL_HIGH_OUTPUT_LEVEL];
         s_nxt.pin_l = wdata_in[CTRL_LOW_OUTPUT_LEVEL];
      end
      else
      begin
         s_nxt.pin_h = s_r.pin_h ^ match_h;
         s_nxt.pin_l = s_r.pin_l ^ match_l;
      end
      // Reads; the control register is write-only and reads as all ones
      if (rd_in)
      begin
         unique case (addr_in)
            ADDR_STAT: s_nxt.rdata = s_r.stat;
            ADDR_CNT_H:
            begin
               s_nxt.rdata = s_r.cnt_h;
               if (!mode8)
               begin
                  s_nxt.temp = s_r.cnt_l;
               end
            end
            ADDR_CNT_L: s_nxt.rdata = mode8 ? s_r.cnt_l : s_r.temp;
            ADDR_CMP_H: s_nxt.rdata = s_r.cmp_h;
            ADDR_CMP_L: s_nxt.rdata = s_r.cmp_l;
            default: s_nxt.rdata = READ_IDLE;
         endcase
      end
   end

   // State register
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         s_r.ctrl <= CTRL_RESET;
         s_r.stat <= STAT_RESET;
         s_r.cnt_h <= CNT_RESET;
         s_r.cnt_l <= CNT_RESET;
         s_r.cmp_h <= CMP_RESET;
         s_r.cmp_l <= CMP_RESET;
         s_r.temp <= CNT_RESET;
         s_r.rdata <= READ_IDLE;
         s_r.pin_h <= 1'b0;
         s_r.pin_l <= 1'b0;
         s_r.req_h <= 1'b0;
         s_r.req_l <= 1'b0;
         s_r.irq_h <= 1'b0;
         s_r.irq_l <= 1'b0;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from the state register
   assign rdata_out = s_r.rdata;
   assign high_toggle_pin_out = s_r.pin_h;
   assign low_toggle_pin_out = s_r.pin_l;
   assign high_irq_request_flag_out = s_r.req_h;
   assign low_irq_request_flag_out = s_r.req_l;
   assign high_irq_out = s_r.irq_h;
   assign low_irq_out = s_r.irq_l;

   // Checks on the behaviour above
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   sequence s_match16;
      !mode8 && tick_l && ({s_r.cnt_h, s_r.cnt_l} == {s_r.cmp_h, s_r.cmp_l}) && !wr_in;
   endsequence

   sequence s_wr_hi16;
      !mode8 && wr_cnt_h && !rd_in;
   endsequence

   sequence s_wr_lo16;
      !mode8 && wr_cnt_l && !rd_in;
   endsequence

   sequence s_rd_hi16;
      !mode8 && rd_in && (addr_in == ADDR_CNT_H) && !wr_in;
   endsequence

   a_reset_counts: assert property ($fell(rst_in) |-> (s_r.cnt_h == 8'h00) && (s_r.cnt_l == 8'h00)) else $error("counter not zero after reset");
   a_reset_compare: assert property ($fell(rst_in) |-> (s_r.cmp_h == 8'hff) && (s_r.cmp_l == 8'hff) && (s_r.ctrl == 8'h00)) else $error("compare or control bad after reset");
   // Enable is sampled with the match, so compare against its past value
   a_match_flags: assert property (s_match16 |=> s_r.stat[STAT_HIGH_MATCH_FLAG] && s_r.req_h && (s_r.irq_h == $past(high_irq_enable_in))) else $error("16-bit match did not set flags");
   a_match_toggle: assert property (s_match16 |=> s_r.pin_h != $past(s_r.pin_h)) else $error("high pin did not toggle");
   a_match_clear: assert property (s_match16 ##0 s_r.stat[STAT_HIGH_CLEAR_ON_MATCH] |=> (s_r.cnt_h == 8'h00) && (s_r.cnt_l == 8'h00)) else $error("counter not cleared on match");
   a_ovf_16: assert property (!mode8 && tick_l && (s_r.cnt_h == 8'hff) && (s_r.cnt_l == 8'hff) && !s_r.stat[STAT_HIGH_CLEAR_ON_MATCH] && !wr_in |=> s_r.stat[STAT_HIGH_OVERFLOW_FLAG] && (s_r.cnt_h == 8'h00)) else $error("16-bit overflow missed");
   a_wr_pair: assert property (s_wr_hi16 ##1 s_wr_lo16 |=> ({s_r.cnt_h, s_r.cnt_l} == {$past(wdata_in, 2), $past(wdata_in)})) else $error("16-bit write not coherent");
   a_rd_pair: assert property (s_rd_hi16 ##1 (rd_in && (addr_in == ADDR_CNT_L) && !wr_in) |=> s_r.rdata == $past(s_r.cnt_l, 2)) else $error("16-bit read not coherent");
   a_low_match: assert property (mode8 && tick_l && (s_r.cnt_l == s_r.cmp_l) && !wr_in |=> s_r.stat[STAT_LOW_MATCH_FLAG] && s_r.req_l && (s_r.pin_l != $past(s_r.pin_l))) else $error("low 8-bit match missed");
   a_match_suppress: assert property (mode8 && match_l == 1'b0 && tick_l && wr_cmp_l && (s_r.cnt_l == s_r.cmp_l) |=> s_r.stat[STAT_LOW_MATCH_FLAG] == $past(s_r.stat[STAT_LOW_MATCH_FLAG])) else $error("low match not suppressed by write");

endmodule

// file: include/cmt_pkg.sv
// Constants shared by the compare match timer: register offsets, field
// positions, reset values, clock codes and prescaler taps.
// Assumes a byte-wide CPU bus with a 4-bit offset inside the timer block.
package cmt_pkg;

   // Register offsets on the byte bus
   localparam logic [3:0] ADDR_CTRL = 4'h6;
   localparam logic [3:0] ADDR_STAT = 4'h7;
   localparam logic [3:0] ADDR_CNT_H = 4'h8;
   localparam logic [3:0] ADDR_CNT_L = 4'h9;
   localparam logic [3:0] ADDR_CMP_H = 4'ha;
   localparam logic [3:0] ADDR_CMP_L = 4'hb;

   // Timer control fields
   localparam int CTRL_HIGH_OUTPUT_LEVEL = 7;
   localparam int CTRL_MODE = 6;
   localparam int CTRL_CKSH_HI = 5;
   localparam int CTRL_CKSH_LO = 4;
   localparam int CTRL_LOW_OUTPUT_LEVEL = 3;
   localparam int CTRL_CKSL_EXT = 2;
   localparam int CTRL_CKSL_HI = 1;
   localparam int CTRL_CKSL_LO = 0;

   // Timer control/status fields
   localparam int STAT_HIGH_OVERFLOW_FLAG = 7;
   localparam int STAT_HIGH_MATCH_FLAG = 6;
   localparam int STAT_HIGH_OVERFLOW_IRQ_ENABLE = 5;
   localparam int STAT_HIGH_CLEAR_ON_MATCH = 4;
   localparam int STAT_LOW_OVERFLOW_FLAG = 3;
   localparam int STAT_LOW_MATCH_FLAG = 2;
   localparam int STAT_LOW_OVERFLOW_IRQ_ENABLE = 1;
   localparam int STAT_LOW_CLEAR_ON_MATCH = 0;

   // Reset values, and the byte maximum
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] STAT_RESET = 8'h00;
   localparam logic [7:0] CNT_RESET = 8'h00;
   localparam logic [7:0] CMP_RESET = 8'hff;
   localparam logic [7:0] READ_IDLE = 8'hff;
   localparam logic [7:0] BYTE_MAX = 8'hff;

   // Internal clock codes of a two-bit clock select field
   localparam logic [1:0] CS_DIV32 = 2'h0;
   localparam logic [1:0] CS_DIV16 = 2'h1;
   localparam logic [1:0] CS_DIV4 = 2'h2;
   localparam logic [1:0] CS_SUB4 = 2'h3;

   // Prescaler taps: a tick when the low bits of the prescaler are all ones
   localparam logic [4:0] PRE_MASK32 = 5'h1f;
   localparam logic [4:0] PRE_MASK16 = 5'h0f;
   localparam logic [4:0] PRE_MASK4 = 5'h03;
   localparam logic [1:0] SUB_LAST = 2'h3;

endpackage

// file: core/cmt_clk_sel.sv
// Count source selection for both byte counters of the compare match timer.
// Assumes sub_tick_in is a one-cycle pulse per subclock period and that the
// event pin is already synchronous to clk_in.
`timescale 1ns/1ns
module cmt_clk_sel
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Power and standby state
   input wire logic run_in,
   input wire logic low_power_in,
   // Sources
   input wire logic sub_tick_in,
   input wire logic event_in,
   // Selects
   input wire logic [1:0] sel_h_in,
   input wire logic [2:0] sel_l_in,
   // Count ticks
   output logic tick_h_out,
   output logic tick_l_out
);
   import cmt_pkg::*;

   typedef struct packed
   {
      logic [4:0] pre;
      logic [1:0] sub_div;
      logic ev_prev;
      logic tick_h;
      logic tick_l;
   } cmt_clk_t;

   cmt_clk_t s_r;
   cmt_clk_t s_nxt;

   // Internal source decode, shared by both counters
   function automatic logic int_tick(input logic [1:0] code, input logic [4:0] pre,
                                     input logic sub4, input logic lp);
      logic t;
      t = 1'b0;
      unique case (code)
         CS_DIV32: t = ((pre & PRE_MASK32) == PRE_MASK32) && !lp;
         CS_DIV16: t = ((pre & PRE_MASK16) == PRE_MASK16) && !lp;
         CS_DIV4: t = ((pre & PRE_MASK4) == PRE_MASK4) && !lp;
         CS_SUB4: t = sub4;
      endcase
      return t;
   endfunction

   // Prescaler, subclock divider and event edge detect
   always_comb
   begin
      logic sub4;
      logic ev_edge;
      sub4 = 1'b0;
      ev_edge = 1'b0;
      s_nxt = s_r;
      sub4 = sub_tick_in && (s_r.sub_div == SUB_LAST);
      ev_edge = event_in && !s_r.ev_prev; // Rising edge is counted
      s_nxt.ev_prev = event_in;
      s_nxt.tick_h = 1'b0;
      s_nxt.tick_l = 1'b0;
      // Standby stops the prescaler, subclock divider and ticks; the event edge detect keeps tracking
      if (run_in)
      begin
         // System prescaler halts in low-power modes; subclock keeps going
         if (!low_power_in)
         begin
            s_nxt.pre = s_r.pre + 5'h01;
         end
         if (sub_tick_in)
         begin
            s_nxt.sub_div = s_r.sub_div + 2'h1;
         end
         s_nxt.tick_h = int_tick(sel_h_in, s_r.pre, sub4, low_power_in);
         if (sel_l_in[CTRL_CKSL_EXT])
         begin
            s_nxt.tick_l = int_tick(sel_l_in[CTRL_CKSL_HI:CTRL_CKSL_LO], s_r.pre, sub4,
                                    low_power_in);
         end
         else
         begin
            s_nxt.tick_l = ev_edge;
         end
      end
   end

   // State register
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         s_r <= '0;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign tick_h_out = s_r.tick_h;
   assign tick_l_out = s_r.tick_l;

endmodule

// file: tb/cmt_timer_tb.sv
// Self-checking bench for the compare match timer, driving the byte bus,
// the count sources and the interrupt side ports directly.
// Assumes the design's registered read data and its event/subclock timing.
`timescale 1ns/1ns
module cmt_timer_tb;
   import cmt_pkg::*;

   // Design connections
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [3:0] addr_in = 4'h0;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic [7:0] wdata_in = 8'h00;
   logic [7:0] rdata_out;
   logic hi_en = 1'b0;
   logic lo_en = 1'b0;
   logic hi_clr = 1'b0;
   logic lo_clr = 1'b0;
   logic run = 1'b1;
   logic low_pwr = 1'b0;
   logic sub_tick = 1'b0;
   logic ev_pin = 1'b0;
   logic pin_h, pin_l, req_h, req_l, irq_h, irq_l;
   int error_cnt = 0;
   int checked = 0;
   int cyc = 0;

   cmt_timer i_cmt_timer (
      .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wr_in(wr_in),
      .rd_in(rd_in), .wdata_in(wdata_in), .rdata_out(rdata_out),
      .high_irq_enable_in(hi_en), .low_irq_enable_in(lo_en),
      .high_irq_clear_in(hi_clr), .low_irq_clear_in(lo_clr),
      .module_run_in(run), .low_power_in(low_pwr), .sub_tick_in(sub_tick),
      .event_input_pin_in(ev_pin), .high_toggle_pin_out(pin_h),
      .low_toggle_pin_out(pin_l), .high_irq_request_flag_out(req_h),
      .low_irq_request_flag_out(req_l), .high_irq_out(irq_h), .low_irq_out(irq_l));

   // Free-running 100 MHz clock
   always #5 clk_in = ~clk_in;

   // Verdict and end of run, reached from the main flow or the watchdog
   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Watchdog: whole sequence needs well under a thousand cycles
   always @(posedge clk_in)
   begin
      cyc = cyc + 1;
      if (cyc == 5000)
      begin
         error_cnt = error_cnt + 1;
         end_sim();
      end
   end

   // One comparison, counted; case inequality so unknowns never match
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked = checked + 1;
      if (seen !== exp)
      begin
         error_cnt = error_cnt + 1;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Byte write: one-cycle strobe launched just after the edge
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_in);
      #1 addr_in = a;
      wdata_in = d;
      wr_in = 1'b1;
      @(posedge clk_in);
      #1 wr_in = 1'b0;
   endtask

   // Byte read; data is sampled a full cycle later, as it stands until next read
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk_in);
      #1 addr_in = a;
      rd_in = 1'b1;
      @(posedge clk_in);
      #1 rd_in = 1'b0;
      @(posedge clk_in);
      #1 check(rdata_out, exp);
   endtask

   // Event pin rising edges; slack lets the two-cycle tick delay land
   task automatic ev(input int n);
      repeat (n)
      begin
         @(posedge clk_in);
         #1 ev_pin = 1'b1;
         repeat (2) @(posedge clk_in);
         #1 ev_pin = 1'b0;
         repeat (2) @(posedge clk_in);
      end
      repeat (4) @(posedge clk_in);
   endtask

   // Subclock pulses; eight of them give exactly two quarter-rate ticks
   task automatic sub(input int n);
      repeat (n)
      begin
         @(posedge clk_in);
         #1 sub_tick = 1'b1;
         @(posedge clk_in);
         #1 sub_tick = 1'b0;
         repeat (2) @(posedge clk_in);
      end
      repeat (4) @(posedge clk_in);
   endtask

   // Pulse both request clears for one cycle
   task automatic clr_req();
      @(posedge clk_in);
      #1 hi_clr = 1'b1;
      lo_clr = 1'b1;
      @(posedge clk_in);
      #1 hi_clr = 1'b0;
      lo_clr = 1'b0;
      repeat (2) @(posedge clk_in);
   endtask

   // Main sequence
   initial
   begin
      repeat (16) @(posedge clk_in);
      #1 rst_in = 1'b0;
      // Reset values and access kinds
      rd(ADDR_STAT, STAT_RESET);
      rd(ADDR_CNT_H, 8'h00);
      rd(ADDR_CNT_L, 8'h00);
      rd(ADDR_CMP_H, 8'hff);
      rd(ADDR_CMP_L, 8'hff);
      rd(ADDR_CTRL, READ_IDLE);
      rd(4'h0, READ_IDLE);
      check({6'h00, pin_h, pin_l}, 8'h00);
      // Coherent 16-bit write and read through the temporary byte
      wr(ADDR_CNT_H, 8'haa);
      wr(ADDR_CNT_L, 8'h55);
      rd(ADDR_CNT_H, 8'haa);
      rd(ADDR_CNT_L, 8'h55);
      wr(ADDR_CMP_H, 8'h12);
      wr(ADDR_CMP_L, 8'h34);
      rd(ADDR_CMP_H, 8'h12);
      rd(ADDR_CMP_L, 8'h34);
      // 16-bit event counting, match with clear, masked then enabled interrupt
      wr(ADDR_CNT_H, 8'h00);
      wr(ADDR_CNT_L, 8'h00);
      wr(ADDR_CMP_H, 8'h00);
      wr(ADDR_CMP_L, 8'h03);
      wr(ADDR_STAT, 8'h10);
      ev(3);
      rd(ADDR_CNT_H, 8'h00);
      rd(ADDR_CNT_L, 8'h03);
      check({7'h00, req_h}, 8'h00);
      ev(1);
      #1 check({5'h00, pin_h, req_h, irq_h}, 8'h06);
      hi_en = 1'b1;
      repeat (3) @(posedge clk_in);
      #1 check({7'h00, irq_h}, 8'h01);
      rd(ADDR_STAT, 8'h50);
      rd(ADDR_CNT_H, 8'h00);
      rd(ADDR_CNT_L, 8'h00);
      clr_req();
      #1 check({6'h00, req_h, irq_h}, 8'h00);
      // 16-bit overflow; the low byte wraps as well
      wr(ADDR_STAT, 8'h20);
      wr(ADDR_CNT_H, 8'hff);
      wr(ADDR_CNT_L, 8'hfe);
      ev(2);
      rd(ADDR_STAT, 8'ha8);
      check({7'h00, req_h}, 8'h01);
      rd(ADDR_CNT_H, 8'h00);
      rd(ADDR_CNT_L, 8'h00);
      // Flags clear by writing zero and cannot be set by writing one
      wr(ADDR_STAT, 8'h00);
      wr(ADDR_STAT, 8'hcc);
      rd(ADDR_STAT, 8'h00);
      wr(ADDR_STAT, 8'h00);
      clr_req();
      // Module standby: no counting while the module clock is stopped
      #1 run = 1'b0;
      ev(2);
      rd(ADDR_CNT_H, 8'h00);
      rd(ADDR_CNT_L, 8'h00);
      #1 run = 1'b1;
      // 8-bit mode: high on subclock/4, low on events, levels from control
      wr(ADDR_CTRL, 8'h78);
      repeat (2) @(posedge clk_in);
      #1 check({6'h00, pin_h, pin_l}, 8'h01);
      wr(ADDR_STAT, 8'h21);
      wr(ADDR_CNT_L, 8'h00);
      wr(ADDR_CMP_L, 8'h02);
      wr(ADDR_CNT_H, 8'hfe);
      wr(ADDR_CMP_H, 8'h10);
      rd(ADDR_CNT_H, 8'hfe);
      #1 low_pwr = 1'b1;
      lo_en = 1'b1;
      ev(2);
      rd(ADDR_CNT_L, 8'h02);
      rd(ADDR_CNT_H, 8'hfe);
      ev(1);
      rd(ADDR_CNT_L, 8'h00);
      check({5'h00, pin_l, req_l, irq_l}, 8'h03);
      sub(8);
      rd(ADDR_CNT_H, 8'h00);
      check({6'h00, req_h, pin_h}, 8'h02);
      rd(ADDR_STAT, 8'ha5);
      // 8-bit high match toggles the high pin and sets its match flag
      wr(ADDR_STAT, 8'h00);
      clr_req();
      wr(ADDR_CMP_H, 8'h01);
      sub(4);
      sub(4);
      #1 check({6'h00, req_h, pin_h}, 8'h03);
      rd(ADDR_STAT, 8'h40);
      #1 low_pwr = 1'b0;
      // High level bit set: the high pin is driven high by the control write
      wr(ADDR_CTRL, 8'h80);
      repeat (2) @(posedge clk_in);
      #1 check({6'h00, pin_h, pin_l}, 8'h02);
      end_sim();
   end
endmodule
